/* File: logic/pfm_pkg.sv */
`default_nettype none
package pfm_pkg;

    // ------------------------------------------------------------
    // Timing and sizing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ      = 200_000_000;
    localparam int unsigned DESIGN_IN_HZ     = 1_000;
    localparam int unsigned TICK_OVERSAMPLE  = 100;
    localparam int unsigned FACTOR_W         = 8;
    localparam int unsigned COUNT_W          = 16;
    localparam int unsigned PRESCALE_W       = 16;
    localparam int unsigned MAX_OUT_HZ       = 135_000;
    localparam logic [FACTOR_W-1:0] FACTOR_RESET = 8'h0F;
    localparam logic [COUNT_W-1:0]  COUNT_ZERO   = 16'h0000;
    localparam logic [COUNT_W-1:0]  COUNT_SAT    = 16'hFFFF;
    // Range bounds in ticks: nominal period is TICK_OVERSAMPLE*N ticks
    localparam int unsigned RANGE_LO_DIV     = 5;
    localparam int unsigned RANGE_HI_MUL     = 5;

    typedef enum logic [1:0] {
        PFM_MEASURE  = 2'b00,
        PFM_GENERATE = 2'b01
    } pfm_role_e;

endpackage : pfm_pkg
`default_nettype wire

/* File: logic/pfm_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module pfm_unit
    import pfm_pkg::*;
(
    // Clock and reset
    input  wire logic                clock_in,
    input  wire logic                rstn_in,
    input  wire logic                enable_in,
    // Control
    input  wire logic                select_in,
    input  wire logic                tick_in,
    input  wire logic                start_in,
    input  wire logic [FACTOR_W:0]   counter_terminal_value_in,
    // Results
    output logic [COUNT_W-1:0]       period_out,
    output logic                     edge_out
);

    typedef struct packed {
        pfm_role_e            role;
        logic [COUNT_W-1:0]   count;
        logic [COUNT_W-1:0]   period;
        logic [COUNT_W-1:0]   gen_count;
        logic [FACTOR_W:0]    edges;
        logic                 edge_p;
    } pfm_unit_s;

    pfm_unit_s state;
    pfm_unit_s next_state;
    logic [COUNT_W+FACTOR_W:0] scaled;
    logic [COUNT_W-1:0]        step;

    always_comb
    begin
        next_state        = state;
        next_state.edge_p = 1'b0;
        scaled = '0;
        step   = '0;
        next_state.role = select_in ? PFM_GENERATE : PFM_MEASURE;
        unique case (state.role)
            PFM_MEASURE:
            begin
                if (start_in)
                begin
                    next_state.period = state.count;
                    next_state.count  = COUNT_ZERO;
                end
                else if (tick_in && state.count != COUNT_SAT)
                begin
                    next_state.count = state.count + 16'h0001;
                end
                next_state.gen_count = COUNT_ZERO;
                next_state.edges     = '0;
            end
            PFM_GENERATE:
            begin
                // split period into CD+1 half cycles
                scaled = {{(FACTOR_W+1){1'b0}}, state.period};
                step = COUNT_W'(scaled / ({{(COUNT_W){1'b0}}, counter_terminal_value_in}
                       + 25'd1));
                if (step == COUNT_ZERO)
                begin
                    step = 16'h0001;
                end
                next_state.count = COUNT_ZERO;
                // unit comparator
                if (tick_in)
                begin
                    if (state.gen_count + 16'h0001 >= step
                        && state.edges <= counter_terminal_value_in)
                    begin
                        next_state.gen_count = COUNT_ZERO;
                        next_state.edges     = state.edges + {{FACTOR_W{1'b0}}, 1'b1};
                        next_state.edge_p    = 1'b1;
                    end
                    else
                    begin
                        next_state.gen_count = state.gen_count + 16'h0001;
                    end
                end
            end
            default:
            begin
                next_state.role = PFM_MEASURE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state <= '{role: PFM_MEASURE, count: COUNT_ZERO, period: COUNT_ZERO,
                       gen_count: COUNT_ZERO, edges: '0, edge_p: 1'b0};
        end
        else if (enable_in)
        begin
            state <= next_state;
        end
    end

    assign period_out = state.period;
    assign edge_out   = state.edge_p;

endmodule : pfm_unit
`default_nettype wire

/* File: logic/pfm_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pfm_top
    import pfm_pkg::*;
(
    // Clock and reset
    input  wire logic                clock_in,
    input  wire logic                rstn_in,
    input  wire logic                enable_in,
    // Configuration
    input  wire logic [FACTOR_W-1:0] factor_in,
    input  wire logic [PRESCALE_W-1:0] tick_divide_in,
    // Pulse input pin
    input  wire logic                pulse_in,
    // Outputs
    output logic                     multiplied_out,
    output logic                     in_range_out
);

    typedef struct packed {
        logic [1:0]            sync;
        logic                  prev;
        logic                  select;
        logic [PRESCALE_W-1:0] presc;
        logic                  tick;
        logic                  boundary;
        logic                  judge;
        logic                  in_range;
        logic                  out_flop;
        logic [FACTOR_W:0]     terminal;
    } pfm_top_s;

    pfm_top_s state;
    pfm_top_s next_state;
    logic [COUNT_W-1:0] period_u [2];
    logic [1:0]         edge_u;
    logic [COUNT_W-1:0] last_period;
    logic [COUNT_W+FACTOR_W:0] nominal;

    // ------------------------------------------------------------
    // Control path
    // ------------------------------------------------------------
    always_comb
    begin
        next_state          = state;
        next_state.sync     = {state.sync[0], pulse_in};
        next_state.prev     = state.sync[1];
        next_state.boundary = state.sync[1] & ~state.prev;
        next_state.judge    = state.boundary;
        next_state.terminal = {factor_in, 1'b0} - 9'd1;
        // reference tick prescaler set by software divider
        next_state.tick = 1'b0;
        if (state.presc >= tick_divide_in)
        begin
            next_state.presc = '0;
            next_state.tick  = 1'b1;
        end
        else
        begin
            next_state.presc = state.presc + 16'h0001;
        end
        // Generating unit holds the period that has just landed
        last_period = state.select ? period_u[0] : period_u[1];
        nominal     = (COUNT_W+FACTOR_W+1)'(TICK_OVERSAMPLE) * {9'd0, factor_in};
        if (state.judge)
        begin
            next_state.in_range =
                ({9'd0, last_period} * 25'(RANGE_HI_MUL) >= nominal) &&
                ({9'd0, last_period} <= nominal * 25'(RANGE_LO_DIV)) &&
                (factor_in != '0);
        end
        if (state.boundary)
        begin
            next_state.select = ~state.select;
            // Keep output phase aligned to the input edge
            next_state.out_flop = 1'b0;
        end
        // Only the generating unit may toggle the flop
        else if (state.select ? edge_u[0] : edge_u[1])
        begin
            next_state.out_flop = ~state.out_flop;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state <= '{sync: 2'b00, prev: 1'b0, select: 1'b0, presc: '0, tick: 1'b0,
                       boundary: 1'b0, judge: 1'b0, in_range: 1'b0, out_flop: 1'b0,
                       terminal: '0};
        end
        else if (enable_in)
        begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Measure and generate units
    // ------------------------------------------------------------
    // two identical units
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_unit
            pfm_unit u_unit (
                .clock_in                  (clock_in),
                .rstn_in                   (rstn_in),
                .enable_in                 (enable_in),
                .select_in                 (gi == 0 ? state.select : ~state.select),
                .tick_in                   (state.tick),
                .start_in                  (state.boundary),
                .counter_terminal_value_in (state.terminal),
                .period_out                (period_u[gi]),
                .edge_out                  (edge_u[gi])
            );
        end
    endgenerate

    // output low while out of range
    assign multiplied_out = state.out_flop & state.in_range;
    assign in_range_out   = state.in_range;

endmodule : pfm_top
`default_nettype wire

/* File: sim/pfm_pulse_source.sv */
`timescale 1ns/1ps
`default_nettype none
module pfm_pulse_source (
    // Control
    input  wire logic        clock_in,
    input  wire logic        run_in,
    input  wire logic [15:0] period_in,
    // Pin
    output logic             pulse_out
);
    logic [15:0] phase = 16'h0000;
    // ------------------------------------------------------------
    // Half-period high square wave, low when idle
    // ------------------------------------------------------------
    always @(negedge clock_in)
    begin
        phase <= (!run_in || phase + 16'h0001 >= period_in) ? 16'h0000 : phase + 16'h0001;
        pulse_out <= run_in && (phase < (period_in >> 1));
    end
endmodule : pfm_pulse_source
`default_nettype wire

/* File: sim/pfm_props.sv */
`timescale 1ns/1ps
`default_nettype none
module pfm_props
    import pfm_pkg::*;
(
    // Clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  rstn_in,
    input  wire logic                  enable_in,
    // Inputs and outputs
    input  wire logic [FACTOR_W-1:0]   factor_in,
    input  wire logic [PRESCALE_W-1:0] tick_divide_in,
    input  wire logic                  pulse_in,
    input  wire logic                  multiplied_out,
    input  wire logic                  in_range_out
);
    // ------------------------------------------------------------
    // Boundary tracking
    // ------------------------------------------------------------
    logic       prev_pulse;
    logic [3:0] since_rise;
    logic [1:0] rises_seen;
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            prev_pulse <= 1'b0;
            since_rise <= 4'hF;
            rises_seen <= 2'h0;
        end
        else if (enable_in)
        begin
            prev_pulse <= pulse_in;
            if (pulse_in && !prev_pulse)
                since_rise <= 4'h0;
            else if (since_rise != 4'hF)
                since_rise <= since_rise + 4'h1;
            if (pulse_in && !prev_pulse && rises_seen != 2'h3)
                rises_seen <= rises_seen + 2'h1;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    sequence s_after_boundary;
        since_rise inside {[5:8]};
    endsequence
    a_out_low_range: assert property (!in_range_out |-> !multiplied_out) else $error("out high");
    a_reset_quiet: assert property ($rose(rstn_in) |-> !in_range_out && !multiplied_out) else $error("reset");
    a_range_moment: assert property ($changed(in_range_out) |-> since_rise inside {[2:6]}) else $error("range time");
    a_range_second: assert property ($rose(in_range_out) |-> rises_seen >= 2'h2) else $error("range early");
    a_flop_boundary: assert property (s_after_boundary |-> !multiplied_out) else $error("no restart");
    a_high_min: assert property ($rose(multiplied_out) |=> multiplied_out) else $error("glitch");
    a_factor_zero: assert property (since_rise == 4'h6 && factor_in == 8'h00 && $past(factor_in, 8) == 8'h00 |-> !in_range_out) else $error("zero");
    a_freeze_hold: assert property (!enable_in |=> $stable(multiplied_out) && $stable(in_range_out)) else $error("freeze");
endmodule : pfm_props
bind pfm_top pfm_props pfm_props_inst (.clock_in(clock_in), .rstn_in(rstn_in),
    .enable_in(enable_in), .factor_in(factor_in), .tick_divide_in(tick_divide_in),
    .pulse_in(pulse_in), .multiplied_out(multiplied_out), .in_range_out(in_range_out));
`default_nettype wire

/* File: sim/pulse_frequency_multiplier_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_frequency_multiplier_bench;
    import pfm_pkg::*;
    logic                clock_in, rstn_in, enable_in, pulse_in, run, multiplied_out, in_range_out;
    logic [FACTOR_W-1:0] factor_in;
    logic [15:0]         period;
    logic [PRESCALE_W-1:0] tick_divide;
    int                  fails, check_count, rises, highs, ins;
    pfm_top pfm_top_inst (.clock_in(clock_in), .rstn_in(rstn_in), .enable_in(enable_in),
        .factor_in(factor_in), .tick_divide_in(tick_divide), .pulse_in(pulse_in),
        .multiplied_out(multiplied_out), .in_range_out(in_range_out));
    pfm_pulse_source pfm_pulse_source_inst (.clock_in(clock_in), .run_in(run),
        .period_in(period), .pulse_out(pulse_in));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task measure(input int n);
        logic last;
        rises = 0;
        highs = 0;
        ins = 0;
        last = 1'b1;
        repeat (n * period) @(negedge clock_in)
        begin
            highs += (multiplied_out === 1'b1);
            rises += (multiplied_out === 1'b1 && last !== 1'b1);
            ins += (in_range_out === 1'b1);
            last = multiplied_out;
        end
    endtask : measure
    task t_in_range;
        for (int n = 1; n <= 3; n++)
        begin
            factor_in = n;
            period = 100 * n;
            measure(3);
            measure(4);
            check(ins == 4 * period, 1, "in range");
            check(rises inside {[4 * n - 1 : 4 * n]}, 1, "edges");
            check(highs inside {[7 * period / 4 : 9 * period / 4]}, 1, "duty");
        end
        $display("t_in_range done");
    endtask : t_in_range
    task t_out_range;
        logic [23:0] cases [3] = '{24'h02_001E, 24'h02_04B0, 24'h00_00C8};
        foreach (cases[i])
        begin
            factor_in = cases[i][23:16];
            period = cases[i][15:0];
            measure(3);
            measure(3);
            check(ins, 0, "range low");
            check(highs, 0, "out low");
        end
        $display("t_out_range done");
    endtask : t_out_range
    task t_freeze;
        logic [1:0] held;
        factor_in = 2;
        period = 200;
        measure(4);
        enable_in = 1'b0;
        held = {multiplied_out, in_range_out};
        rises = 0;
        repeat (150) @(negedge clock_in)
            rises += ({multiplied_out, in_range_out} !== held);
        enable_in = 1'b1;
        check(held[0], 1'b1, "range before freeze");
        check(rises, 0, "frozen");
        $display("t_freeze done");
    endtask : t_freeze
    task t_prescale;
        factor_in = 2;
        tick_divide = 16'h0001;
        period = 400;
        measure(3);
        measure(4);
        check(ins == 4 * period, 1, "slow ticks in range");
        check(rises inside {[7:8]}, 1, "slow ticks edges");
        tick_divide = 16'h0009;
        period = 200;
        measure(3);
        measure(3);
        check(ins, 0, "slow ticks out of range");
        $display("t_prescale done");
    endtask : t_prescale
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    initial
    begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    initial
    begin
        {fails, check_count} = 0;
        {rstn_in, run, enable_in, factor_in, period, tick_divide} =
            {3'b001, 8'h02, 16'h00C8, 16'h0000};
        repeat (5) @(posedge clock_in);
        @(negedge clock_in);
        rstn_in = 1'b1;
        run = 1'b1;
        repeat (50) @(negedge clock_in);
        check({multiplied_out, in_range_out}, 16'h0000, "first period");
        t_in_range();
        t_out_range();
        t_freeze();
        t_prescale();
        give_verdict();
    end
endmodule : pulse_frequency_multiplier_bench
`default_nettype wire
